// >>> common/sgdir_pkg.sv
// Constants shared by the strap, pulldown, debug and interrupt register slice.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package sgdir_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_STRAP_STATUS = 8'hb8;
  localparam logic [IDX_W-1:0] IDX_PULLDOWN_CTL = 8'hbe;
  localparam logic [IDX_W-1:0] IDX_PORT_STATUS_ONE = 8'hc0;
  localparam logic [IDX_W-1:0] IDX_PORT_STATUS_TWO = 8'hc1;
  localparam logic [IDX_W-1:0] IDX_PORT_DEBUG = 8'hd0;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE_HI = 8'hd8;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS_HI = 8'hda;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STRAP_DONE_BIT = 3;
  localparam int STRAP_MODE_W = 3;
  localparam int NUM_PINS = 3;
  localparam int DBG_SELFTEST_BIT = 5;
  localparam int DBG_CONT_BIT = 1;
  localparam int DBG_SINGLE_BIT = 0;
  localparam int IRQ_ENC_BIT = 2;
  localparam int IRQ_SEQ_BIT = 1;
  localparam int IRQ_CRC_BIT = 0;
  localparam int STS1_SEQ_BIT = 1;
  localparam int STS1_CRC_BIT = 0;
  localparam int STS2_ENC_BIT = 0;
  localparam int NUM_IRQ = 3;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [REG_W-1:0] PULLDOWN_RESET = 8'h00;
  localparam logic [REG_W-1:0] DEBUG_RESET = 8'h00;
  localparam logic [REG_W-1:0] DEBUG_STORE_MASK = 8'hdc;
  localparam logic [NUM_IRQ-1:0] IRQ_EN_RESET = 3'h0;
  localparam logic [STRAP_MODE_W-1:0] STRAP_MODE_RESET = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CNT_W = 8;

  // ****************************************
  // Bus answers and states
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SGDIR_STRAP_SETTLE = 2'b00,
    SGDIR_STRAP_LATCH = 2'b01,
    SGDIR_STRAP_DONE = 2'b10
  } sgdir_strap_state_t;

endpackage

// >>> src/sgdir_flag.sv
// Sticky event flag, set by hardware and cleared by a read.
// Assumes set and clear are single-cycle pulses in the system clock domain.
`timescale 1ns/10ps
module sgdir_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Events
  input wire logic set,
  input wire logic clear,
  // State
  output logic q
);

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clear) begin
      q <= 1'b0;
    end
  end

endmodule

// >>> src/sgdir_axil.sv
// AXI4-Lite slave front end turning bus traffic into register strobes.
// Assumes the register file answers a read combinationally in the strobe cycle.
`timescale 1ns/10ps
module sgdir_axil
  import sgdir_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write address and data
  input wire logic [sgdir_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [sgdir_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [sgdir_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [sgdir_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register strobes
  output logic wr_en,
  output logic [sgdir_pkg::IDX_W-1:0] wr_idx,
  output logic [sgdir_pkg::REG_W-1:0] wr_data,
  input wire logic wr_hit,
  output logic rd_en,
  output logic [sgdir_pkg::IDX_W-1:0] rd_idx,
  input wire logic [sgdir_pkg::REG_W-1:0] rd_data,
  input wire logic rd_hit
);

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [REG_W-1:0] w_data;
  logic w_lane0;
  wire wr_aligned = (aw_addr[1:0] == 2'h0);
  wire rd_aligned = (araddr[1:0] == 2'h0);
  wire wr_fire = aw_held && w_held && !bvalid;

  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;
  // Only byte lane 0 carries register bits; lane 0 off makes the write a no-op
  assign wr_en = wr_fire && wr_aligned && w_lane0;
  assign wr_idx = aw_addr[ADDR_W-1:2];
  assign wr_data = w_data;
  assign rd_en = arvalid && arready && rd_aligned;
  assign rd_idx = araddr[ADDR_W-1:2];

  // ****************************************
  // Write path
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata[REG_W-1:0];
        w_lane0 <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_aligned && wr_hit) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {{(DATA_W-REG_W){1'b0}}, (rd_aligned && rd_hit) ? rd_data : 8'h00};
      rresp <= (rd_aligned && rd_hit) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// >>> src/sgdir_regs.sv
// Strap status, pin pulldown, port debug and upper interrupt register slice.
// Assumes link-side event inputs are one-cycle pulses synchronous to CLK_SYS.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps

module sgdir_regs
  import sgdir_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // AXI4-Lite write
  input wire logic [sgdir_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [sgdir_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [sgdir_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [sgdir_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Mode strap
  input wire logic [sgdir_pkg::STRAP_MODE_W-1:0] MODE_STRAP,
  output logic [sgdir_pkg::STRAP_MODE_W-1:0] STRAP_MODE,
  output logic STRAP_DONE,
  // General-purpose pins
  input wire logic [sgdir_pkg::NUM_PINS-1:0] GPIO_OUT_EN,
  output logic [sgdir_pkg::NUM_PINS-1:0] GPIO_PULLDOWN_EN,
  // Link side
  input wire logic REMOTE_SELFTEST,
  input wire logic BACKCHAN_FRAME_START,
  output logic BACKCHAN_CORRUPT,
  input wire logic LINK_ENCODE_ERR,
  input wire logic CTRL_SEQ_ERR,
  input wire logic CTRL_CRC_ERR,
  // Interrupt
  output logic IRQ
);

  // ****************************************
  // Register bus front end
  // ****************************************
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [REG_W-1:0] wr_data;
  logic wr_hit;
  logic rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic [REG_W-1:0] rd_data;
  logic rd_hit;

  sgdir_axil u_axil (
    .clk(CLK_SYS),
    .reset(RESET),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_hit(wr_hit),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ****************************************
  // Address decode
  // ****************************************
  wire wr_pulldown = wr_en && (wr_idx == IDX_PULLDOWN_CTL);
  wire wr_debug = wr_en && (wr_idx == IDX_PORT_DEBUG);
  wire wr_irq_en = wr_en && (wr_idx == IDX_IRQ_ENABLE_HI);
  wire rd_sts_one = rd_en && (rd_idx == IDX_PORT_STATUS_ONE);
  wire rd_sts_two = rd_en && (rd_idx == IDX_PORT_STATUS_TWO);

  // Status-only registers accept writes silently so software can sweep the map
  assign wr_hit = (wr_idx == IDX_STRAP_STATUS) || (wr_idx == IDX_PULLDOWN_CTL) ||
                  (wr_idx == IDX_PORT_STATUS_ONE) || (wr_idx == IDX_PORT_STATUS_TWO) ||
                  (wr_idx == IDX_PORT_DEBUG) || (wr_idx == IDX_IRQ_ENABLE_HI) ||
                  (wr_idx == IDX_IRQ_STATUS_HI);
  assign rd_hit = (rd_idx == IDX_STRAP_STATUS) || (rd_idx == IDX_PULLDOWN_CTL) ||
                  (rd_idx == IDX_PORT_STATUS_ONE) || (rd_idx == IDX_PORT_STATUS_TWO) ||
                  (rd_idx == IDX_PORT_DEBUG) || (rd_idx == IDX_IRQ_ENABLE_HI) ||
                  (rd_idx == IDX_IRQ_STATUS_HI);

  // ****************************************
  // Mode strap decode
  // ****************************************
  sgdir_strap_state_t strap_state;
  sgdir_strap_state_t next_strap_state;
  logic [SETTLE_CNT_W-1:0] settle_cnt;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(STRAP_SETTLE_CYC - 1);

  // Pin is sampled only after it had time to settle past reset
  always_comb begin
    next_strap_state = strap_state;
    unique case (strap_state)
      SGDIR_STRAP_SETTLE: begin
        if (settle_cnt == SETTLE_LAST) begin
          next_strap_state = SGDIR_STRAP_LATCH;
        end
      end
      SGDIR_STRAP_LATCH: begin
        next_strap_state = SGDIR_STRAP_DONE;
      end
      SGDIR_STRAP_DONE: begin
        next_strap_state = SGDIR_STRAP_DONE;
      end
      default: begin
        next_strap_state = SGDIR_STRAP_SETTLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      strap_state <= SGDIR_STRAP_SETTLE;
      settle_cnt <= '0;
    end else begin
      strap_state <= next_strap_state;
      if (strap_state == SGDIR_STRAP_SETTLE) begin
        settle_cnt <= settle_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      STRAP_MODE <= STRAP_MODE_RESET;
      STRAP_DONE <= 1'b0;
    end else if (strap_state == SGDIR_STRAP_LATCH) begin
      STRAP_MODE <= MODE_STRAP;
      STRAP_DONE <= 1'b1;
    end
  end

  // ****************************************
  // Pin pulldowns
  // ****************************************
  logic [REG_W-1:0] pulldown_ctl;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pulldown_ctl <= PULLDOWN_RESET;
    end else if (wr_pulldown) begin
      pulldown_ctl <= wr_data;
    end
  end

  // Output pins never need the pulldown; the off bit overrides it for inputs
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      GPIO_PULLDOWN_EN <= '0;
    end else begin
      GPIO_PULLDOWN_EN <= ~GPIO_OUT_EN & ~pulldown_ctl[NUM_PINS-1:0];
    end
  end

  // ****************************************
  // Port debug and back-channel errors
  // ****************************************
  logic [REG_W-1:0] debug_store;
  logic inject_backchan_errors_cont;
  logic inject_single_backchan_error;
  logic remote_selftest_active;
  wire single_taken = BACKCHAN_FRAME_START && inject_single_backchan_error;
  wire single_write = wr_debug && wr_data[DBG_SINGLE_BIT];

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      debug_store <= DEBUG_RESET;
      inject_backchan_errors_cont <= 1'b0;
      remote_selftest_active <= 1'b0;
    end else begin
      remote_selftest_active <= REMOTE_SELFTEST;
      if (wr_debug) begin
        debug_store <= wr_data & DEBUG_STORE_MASK;
        inject_backchan_errors_cont <= wr_data[DBG_CONT_BIT];
      end
    end
  end

  // A new write of the single-shot bit beats the self-clear of the old one
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      inject_single_backchan_error <= 1'b0;
    end else if (single_write) begin
      inject_single_backchan_error <= 1'b1;
    end else if (single_taken) begin
      inject_single_backchan_error <= 1'b0;
    end
  end

  // Corruption spans whole frames so one request damages exactly one frame
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      BACKCHAN_CORRUPT <= 1'b0;
    end else if (BACKCHAN_FRAME_START) begin
      BACKCHAN_CORRUPT <= inject_backchan_errors_cont || inject_single_backchan_error;
    end
  end

  // ****************************************
  // Interrupt enables and latched conditions
  // ****************************************
  logic [NUM_IRQ-1:0] irq_enable;
  logic [NUM_IRQ-1:0] irq_pending;
  logic link_encode_err_flag;
  logic ctrl_seq_err_flag;
  logic ctrl_crc_err_flag;
  wire [NUM_IRQ-1:0] irq_event = {LINK_ENCODE_ERR, CTRL_SEQ_ERR, CTRL_CRC_ERR};
  wire [NUM_IRQ-1:0] irq_clear = {rd_sts_two, rd_sts_one, rd_sts_one};

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_enable <= IRQ_EN_RESET;
    end else if (wr_irq_en) begin
      irq_enable <= wr_data[NUM_IRQ-1:0];
    end
  end

  // Latched conditions, one per error source
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_pending
      sgdir_flag u_pending (
        .clk(CLK_SYS),
        .reset(RESET),
        .set(irq_event[gi]),
        .clear(irq_clear[gi]),
        .q(irq_pending[gi])
      );
    end
  endgenerate

  // Port status flags, cleared by their own read
  sgdir_flag u_enc_flag (
    .clk(CLK_SYS),
    .reset(RESET),
    .set(LINK_ENCODE_ERR),
    .clear(rd_sts_two),
    .q(link_encode_err_flag)
  );

  sgdir_flag u_seq_flag (
    .clk(CLK_SYS),
    .reset(RESET),
    .set(CTRL_SEQ_ERR),
    .clear(rd_sts_one),
    .q(ctrl_seq_err_flag)
  );

  sgdir_flag u_crc_flag (
    .clk(CLK_SYS),
    .reset(RESET),
    .set(CTRL_CRC_ERR),
    .clear(rd_sts_one),
    .q(ctrl_crc_err_flag)
  );

  // Level output, follows the pending bits one cycle after they change
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_pending & irq_enable);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  wire [REG_W-1:0] strap_word = {4'h0, STRAP_DONE, STRAP_MODE};
  wire [REG_W-1:0] debug_word = debug_store |
                                (8'(remote_selftest_active) << DBG_SELFTEST_BIT) |
                                (8'(inject_backchan_errors_cont) << DBG_CONT_BIT) |
                                (8'(inject_single_backchan_error) << DBG_SINGLE_BIT);
  wire [REG_W-1:0] irq_en_word = {5'h00, irq_enable};
  wire [REG_W-1:0] irq_sts_word = {5'h00, irq_pending};
  wire [REG_W-1:0] sts_one_word = (8'(ctrl_seq_err_flag) << STS1_SEQ_BIT) |
                                  (8'(ctrl_crc_err_flag) << STS1_CRC_BIT);
  wire [REG_W-1:0] sts_two_word = 8'(link_encode_err_flag) << STS2_ENC_BIT;

  assign rd_data = (rd_idx == IDX_STRAP_STATUS) ? strap_word :
                   (rd_idx == IDX_PULLDOWN_CTL) ? pulldown_ctl :
                   (rd_idx == IDX_PORT_DEBUG) ? debug_word :
                   (rd_idx == IDX_IRQ_ENABLE_HI) ? irq_en_word :
                   (rd_idx == IDX_IRQ_STATUS_HI) ? irq_sts_word :
                   (rd_idx == IDX_PORT_STATUS_ONE) ? sts_one_word :
                   (rd_idx == IDX_PORT_STATUS_TWO) ? sts_two_word : 8'h00;

endmodule

// >>> verification/sgdir_regs_sva.sv
// Concurrent checks on the ports of the register slice.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module sgdir_regs_sva
  import sgdir_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Bus
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [sgdir_pkg::DATA_W-1:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // Strap and pins
  input wire logic [sgdir_pkg::STRAP_MODE_W-1:0] STRAP_MODE,
  input wire logic STRAP_DONE,
  input wire logic [sgdir_pkg::NUM_PINS-1:0] GPIO_OUT_EN,
  input wire logic [sgdir_pkg::NUM_PINS-1:0] GPIO_PULLDOWN_EN,
  // Link and interrupt
  input wire logic BACKCHAN_FRAME_START,
  input wire logic BACKCHAN_CORRUPT,
  input wire logic LINK_ENCODE_ERR,
  input wire logic CTRL_SEQ_ERR,
  input wire logic CTRL_CRC_ERR,
  input wire logic IRQ
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  property p_pd_off;
    (GPIO_PULLDOWN_EN & $past(GPIO_OUT_EN)) == 3'h0;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("Pulldown on while pin drives");
  property p_strap_hold;
    STRAP_DONE |=> STRAP_DONE && $stable(STRAP_MODE);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("Strap result changed");
  property p_strap_zero;
    !STRAP_DONE |-> STRAP_MODE == 3'h0;
  endproperty
  a_strap_zero: assert property (p_strap_zero) else $error("Mode shown before decode");
  property p_irq_rise;
    $rose(IRQ) |-> $past(LINK_ENCODE_ERR || CTRL_SEQ_ERR || CTRL_CRC_ERR, 2) || $past(S_AXI_BVALID);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("Interrupt without cause");
  property p_irq_fall;
    $fell(IRQ) |-> $past(S_AXI_ARVALID && S_AXI_ARREADY, 2) || $past(S_AXI_BVALID);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("Interrupt dropped without read");
  property p_corrupt_frame;
    !BACKCHAN_FRAME_START |=> $stable(BACKCHAN_CORRUPT);
  endproperty
  a_corrupt_frame: assert property (p_corrupt_frame) else $error("Corrupt changed mid frame");
  property p_read_one;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_read_one: assert property (p_read_one) else $error("Read answer late");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write response dropped");
  property p_rdata_upper;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("Upper read data not zero");
endmodule

bind sgdir_regs sgdir_regs_sva u_sgdir_regs_sva (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .STRAP_MODE(STRAP_MODE),
  .STRAP_DONE(STRAP_DONE), .GPIO_OUT_EN(GPIO_OUT_EN), .GPIO_PULLDOWN_EN(GPIO_PULLDOWN_EN),
  .BACKCHAN_FRAME_START(BACKCHAN_FRAME_START), .BACKCHAN_CORRUPT(BACKCHAN_CORRUPT),
  .LINK_ENCODE_ERR(LINK_ENCODE_ERR), .CTRL_SEQ_ERR(CTRL_SEQ_ERR), .CTRL_CRC_ERR(CTRL_CRC_ERR), .IRQ(IRQ)
);

// >>> verification/sgdir_regs_bench.sv
// Self-checking bench for the register slice over AXI4-Lite.
// Assumes the design package and a 125 MHz clock.
`timescale 1ns/10ps
module sgdir_regs_bench;
  import sgdir_pkg::*;
  // ****
  // Signals
  // ****
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [9:0] awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, strap_done, corrupt, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] mode_strap = 3'h0, out_en = 3'h0, ev = 3'h0, strap_mode, pd_en;
  logic selftest = 1'b0, fs = 1'b0;
  int failures = 0, total_checks = 0, seed = 58835;

  sgdir_regs u_sgdir_regs (
    .CLK_SYS(clk_sys), .RESET(reset), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MODE_STRAP(mode_strap),
    .STRAP_MODE(strap_mode), .STRAP_DONE(strap_done), .GPIO_OUT_EN(out_en), .GPIO_PULLDOWN_EN(pd_en),
    .REMOTE_SELFTEST(selftest), .BACKCHAN_FRAME_START(fs), .BACKCHAN_CORRUPT(corrupt),
    .LINK_ENCODE_ERR(ev[2]), .CTRL_SEQ_ERR(ev[1]), .CTRL_CRC_ERR(ev[0]), .IRQ(irq)
  );

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ****
  // Tasks
  // ****
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Response ready is raised late at random so a standing answer is exercised
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    int n, st;
    a = 1'b1;
    w = 1'b1;
    b = 1'b1;
    n = 0;
    st = $unsigned($random(seed)) % 4;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((a || w || b) && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (b && bready && bvalid) begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        b = 1'b0;
        bready <= 1'b0;
      end else if (b && n >= st) begin
        bready <= 1'b1;
      end
    end
    if (n >= 100) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] q, input logic [1:0] er);
    logic a, r;
    int n, st;
    a = 1'b1;
    r = 1'b1;
    n = 0;
    st = $unsigned($random(seed)) % 4;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    while ((a || r) && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (a && arready) begin
        a = 1'b0;
        arvalid <= 1'b0;
      end
      if (r && rready && rvalid) begin
        q = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        r = 1'b0;
        rready <= 1'b0;
      end else if (r && n >= st) begin
        rready <= 1'b1;
      end
    end
    if (n >= 100) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic pulse_ev(input logic [2:0] v);
    ev <= v;
    tick(1);
    ev <= 3'h0;
  endtask

  task automatic frame();
    fs <= 1'b1;
    tick(1);
    fs <= 1'b0;
    tick(1);
  endtask

  function automatic logic [2:0] exp_pd(input logic [2:0] oe, input logic [2:0] off);
    return ~oe & ~off;
  endfunction

  function automatic logic [7:0] exp_dbg(input logic [7:0] d, input logic st);
    return (d & 8'hdf) | {2'h0, st, 5'h0};
  endfunction

  // ****
  // Sequence
  // ****
  initial begin
    logic [31:0] q;
    logic [7:0] d;
    logic [7:0] rst_idx [3];
    int n;
    rst_idx = '{IDX_PULLDOWN_CTL, IDX_PORT_DEBUG, IDX_IRQ_ENABLE_HI};
    mode_strap <= 3'($random(seed));
    tick(5);
    reset <= 1'b0;
    tick(1);
    rd(IDX_STRAP_STATUS, q, RESP_OKAY);
    chk("strap early", 32'h0, q);
    for (int i = 0; i < 3; i++) begin
      rd(rst_idx[i], q, RESP_OKAY);
      chk("reset value", 32'h0, q);
    end
    for (n = 0; n < 300 && strap_done !== 1'b1; n++) tick(1);
    if (n >= 300) begin
      failures++;
      complete_run();
    end
    rd(IDX_STRAP_STATUS, q, RESP_OKAY);
    chk("strap status", {28'h0, 1'b1, mode_strap}, q);
    chk("strap port", {29'h0, mode_strap}, {29'h0, strap_mode});
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h00 : 8'($random(seed));
      out_en <= (i == 0) ? 3'h0 : 3'($random(seed));
      wr(IDX_PULLDOWN_CTL, d, RESP_OKAY);
      rd(IDX_PULLDOWN_CTL, q, RESP_OKAY);
      chk("pulldown reg", {24'h0, d}, q);
      chk("pulldown pins", {29'h0, exp_pd(out_en, d[2:0])}, {29'h0, pd_en});
    end
    // Lane 0 strobe off must leave the register untouched
    wstrb <= 4'he;
    wr(IDX_PULLDOWN_CTL, ~d, RESP_OKAY);
    wstrb <= 4'hf;
    rd(IDX_PULLDOWN_CTL, q, RESP_OKAY);
    chk("pulldown lane off", {24'h0, d}, q);
    selftest <= 1'b1;
    d = 8'($random(seed));
    wr(IDX_PORT_DEBUG, d, RESP_OKAY);
    rd(IDX_PORT_DEBUG, q, RESP_OKAY);
    chk("debug reg", {24'h0, exp_dbg(d, 1'b1)}, q);
    selftest <= 1'b0;
    wr(IDX_PORT_DEBUG, 8'h00, RESP_OKAY);
    frame();
    frame();
    chk("corrupt idle", 32'h0, {31'h0, corrupt});
    wr(IDX_PORT_DEBUG, 8'h02, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      frame();
      chk("corrupt cont", 32'h1, {31'h0, corrupt});
    end
    wr(IDX_PORT_DEBUG, 8'h01, RESP_OKAY);
    frame();
    chk("corrupt single", 32'h1, {31'h0, corrupt});
    rd(IDX_PORT_DEBUG, q, RESP_OKAY);
    chk("single cleared", 32'h0, q);
    frame();
    chk("corrupt stop", 32'h0, {31'h0, corrupt});
    wr(IDX_IRQ_ENABLE_HI, 8'hff, RESP_OKAY);
    rd(IDX_IRQ_ENABLE_HI, q, RESP_OKAY);
    chk("irq enable", 32'h7, q);
    for (int k = 0; k < 3; k++) begin
      pulse_ev(3'(1 << k));
      tick(2);
      chk("irq raised", 32'h1, {31'h0, irq});
      rd(IDX_IRQ_STATUS_HI, q, RESP_OKAY);
      chk("irq pending", 32'(1 << k), q);
      rd((k == 2) ? IDX_PORT_STATUS_TWO : IDX_PORT_STATUS_ONE, q, RESP_OKAY);
      chk("port status", (k == 2) ? 32'h1 : 32'(1 << k), q);
      tick(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    wr(IDX_IRQ_ENABLE_HI, 8'h00, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      pulse_ev(3'(1 << k));
      tick(2);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd((k == 2) ? IDX_PORT_STATUS_TWO : IDX_PORT_STATUS_ONE, q, RESP_OKAY);
      chk("masked status", (k == 2) ? 32'h1 : 32'(1 << k), q);
    end
    wr(IDX_IRQ_ENABLE_HI, 8'h07, RESP_OKAY);
    tick(2);
    chk("irq none pending", 32'h0, {31'h0, irq});
    rd(8'h00, q, RESP_SLVERR);
    chk("unmapped read", 32'h0, q);
    wr(8'h01, 8'ha5, RESP_SLVERR);
    complete_run();
  end
endmodule
